/* srwc_pkg.sv */
package srwc_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] PRIMARY_WAKE_OFS  = 8'h0b;
    localparam logic [7:0] SECOND_WAKE_OFS   = 8'h0d;
    localparam logic [7:0] STATUS_OFS        = 8'h0e;
    localparam logic [7:0] WDT_MODE_OFS      = 8'h0f;

    // field positions
    localparam int SRC_LSB       = 2;
    localparam int SRC_MSB       = 4;
    localparam int LEVEL_BIT     = 6;
    localparam int DELAY_SEL_BIT = 5;
    localparam int WDT_SEL_LSB   = 0;
    localparam int WDT_SEL_MSB   = 1;
    localparam int WDT_HALT_BIT  = 2;

    // reset values
    localparam logic [7:0] PRIMARY_WAKE_RST = 8'h00;
    localparam logic [7:0] SECOND_WAKE_RST  = 8'h00;
    localparam logic [7:0] WDT_MODE_RST     = 8'h04;

    // wake pin vector: [7:0] port 2, [10:8] port 3 bits 1..3, [11] port 0 bit 0, [12] bit 7
    localparam int          PIN_W      = 13;
    localparam logic [12:0] MASK_P2LO  = 13'h000f;
    localparam logic [12:0] MASK_P2ALL = 13'h00ff;
    localparam logic [12:0] MASK_P3    = 13'h0700;
    localparam logic [12:0] MASK_P3P0  = 13'h1f00;
    localparam logic [12:0] MASK_P3P2  = 13'h0707;

    // timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          POR_DELAY_US  = 5000;
    localparam int          WDT_MS_0      = 5;
    localparam int          WDT_MS_1      = 10;
    localparam int          WDT_MS_2      = 20;
    localparam int          WDT_MS_3      = 80;
    localparam int          CNT_W         = 20;
    // least times, so counts round up
    localparam logic [19:0] POR_CYCLES  =
        20'((POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] WDT_CYC_0   =
        20'((WDT_MS_0 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] WDT_CYC_1   =
        20'((WDT_MS_1 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] WDT_CYC_2   =
        20'((WDT_MS_2 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] WDT_CYC_3   =
        20'((WDT_MS_3 * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // power state, gray coded along run -> stop -> delay; delay -> run flips both bits
    typedef enum logic [1:0] {
        PS_RUN   = 2'b00,
        PS_STOP  = 2'b01,
        PS_DELAY = 2'b11
    } srwc_pstate_t;

endpackage

/* srwc_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for pin levels
module srwc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [WIDTH-1:0]  async_in,
    output logic      [WIDTH-1:0]  sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    ////////////////////////////////////////////////////////////////////////
    // one pair of flops per bit; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clock) begin
                if (srst) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_out = sync_ff;
endmodule

`default_nettype wire

/* srwc_wdt.sv */
`timescale 1ns/10ps
`default_nettype none

// watchdog counter with four selectable timeouts
module srwc_wdt
    import srwc_pkg::*;
#(
    parameter logic [19:0] CYC_0 = srwc_pkg::WDT_CYC_0,
    parameter logic [19:0] CYC_1 = srwc_pkg::WDT_CYC_1,
    parameter logic [19:0] CYC_2 = srwc_pkg::WDT_CYC_2,
    parameter logic [19:0] CYC_3 = srwc_pkg::WDT_CYC_3
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        run,
    input  wire logic        refresh,
    input  wire logic [1:0]  period_sel,
    output logic             timeout
);
    logic [19:0] count_ff;
    logic [19:0] nxt_count;
    logic        tout_ff;
    logic        nxt_tout;
    logic [19:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // period select picks the terminal count
    always_comb begin
        case (period_sel)
            2'b00:   limit = CYC_0;
            2'b01:   limit = CYC_1;
            2'b10:   limit = CYC_2;
            default: limit = CYC_3;
        endcase
    end

    // count while running; frozen otherwise, cleared by refresh
    always_comb begin
        nxt_count = count_ff;
        nxt_tout  = 1'b0;
        if (refresh) begin
            nxt_count = '0;
        end else if (run) begin
            if (count_ff >= limit - 20'd1) begin
                nxt_count = '0;
                nxt_tout  = 1'b1;
            end else begin
                nxt_count = count_ff + 20'd1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            count_ff <= '0;
            tout_ff  <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tout_ff  <= nxt_tout;
        end
    end

    assign timeout = tout_ff;

    ////////////////////////////////////////////////////////////////////////
    a_wdt_frozen_idle: assert property (@(posedge clock) disable iff (srst)
        (!run && !refresh) |=> ($stable(count_ff) && !timeout))
        else $error("watchdog moved while stopped");
endmodule

`default_nettype wire

/* srwc_top.sv */
`timescale 1ns/10ps
`default_nettype none

module srwc_top
    import srwc_pkg::*;
#(
    parameter logic [19:0] POR_CYC   = srwc_pkg::POR_CYCLES,
    parameter logic [19:0] WDT_CYC_A = srwc_pkg::WDT_CYC_0,
    parameter logic [19:0] WDT_CYC_B = srwc_pkg::WDT_CYC_1,
    parameter logic [19:0] WDT_CYC_C = srwc_pkg::WDT_CYC_2,
    parameter logic [19:0] WDT_CYC_D = srwc_pkg::WDT_CYC_3
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  port2_pins,
    input  wire logic [7:0]  port2_is_output,
    input  wire logic [2:0]  port3_pins,
    input  wire logic        port0_pin0,
    input  wire logic        port0_pin7,
    input  wire logic        port0_out0,
    input  wire logic        port0_out7,
    input  wire logic        primary_wake_req,
    input  wire logic        stop_req,
    input  wire logic        halt_active,
    input  wire logic        wdt_refresh,
    output logic             in_stop,
    output logic             resume_pulse,
    output logic             wdt_timeout
);
    import srwc_pkg::*;

    logic [7:0]         primary_ff;
    logic [7:0]         nxt_primary;
    logic [7:0]         second_ff;
    logic [7:0]         nxt_second;
    logic [7:0]         wdt_mode_ff;
    logic [7:0]         nxt_wdt_mode;
    logic [7:0]         rdata_ff;
    logic [7:0]         nxt_rdata;
    logic [PIN_W-1:0]   pins_raw;
    logic [PIN_W-1:0]   pins_sync;
    logic [PIN_W-1:0]   pin_is_out;
    logic [PIN_W-1:0]   sel_mask;
    logic [PIN_W-1:0]   use_mask;
    logic               use_nor;
    logic [2:0]         source;
    logic               gate_out;
    logic               wake_level;
    logic               evt_ff;
    logic               nxt_evt;
    logic               second_req;
    logic               any_wake;
    srwc_pstate_t       state_ff;
    srwc_pstate_t       nxt_state;
    logic [19:0]        delay_ff;
    logic [19:0]        nxt_delay;
    logic               resume_ff;
    logic               nxt_resume;
    logic               woke_second_ff;
    logic               nxt_woke_second;
    logic               wdt_run;

    ////////////////////////////////////////////////////////////////////////
    // register port: writes land at once, reads answer one cycle later
    always_comb begin
        nxt_primary  = primary_ff;
        nxt_second   = second_ff;
        nxt_wdt_mode = wdt_mode_ff;
        nxt_rdata    = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                PRIMARY_WAKE_OFS: nxt_primary  = reg_wdata;
                SECOND_WAKE_OFS:  nxt_second   = reg_wdata;
                WDT_MODE_OFS:     nxt_wdt_mode = reg_wdata;
                default:          nxt_primary  = primary_ff;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                PRIMARY_WAKE_OFS: nxt_rdata = primary_ff;
                // source and level cannot be read back
                SECOND_WAKE_OFS:  nxt_rdata = 8'h00;
                WDT_MODE_OFS:     nxt_rdata = wdt_mode_ff;
                STATUS_OFS:       nxt_rdata = {4'h0, woke_second_ff, evt_ff, state_ff};
                default:          nxt_rdata = 8'h00;
            endcase
        end
    end

    // power-on values: source field zero means no pin can end stop
    always_ff @(posedge clock) begin
        if (srst) begin
            primary_ff  <= PRIMARY_WAKE_RST;
            second_ff   <= SECOND_WAKE_RST;
            wdt_mode_ff <= WDT_MODE_RST;
            rdata_ff    <= 8'h00;
        end else begin
            primary_ff  <= nxt_primary;
            second_ff   <= nxt_second;
            wdt_mode_ff <= nxt_wdt_mode;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // pins come from outside the clock domain
    assign pins_raw   = {port0_pin7, port0_pin0, port3_pins, port2_pins};
    // port 3 bits 1..3 are fixed inputs
    assign pin_is_out = {port0_out7, port0_out0, 3'b000, port2_is_output};

    srwc_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // source decode into a pin mask and gate type
    assign source     = second_ff[SRC_MSB:SRC_LSB];
    assign wake_level = second_ff[LEVEL_BIT];

    always_comb begin
        sel_mask = '0;
        use_nor  = 1'b0;
        case (source)
            3'b001:  sel_mask = MASK_P2LO;
            3'b010:  sel_mask = MASK_P2ALL;
            3'b011: begin
                sel_mask = MASK_P3;
                use_nor  = 1'b1;
            end
            3'b100:  sel_mask = MASK_P3;
            3'b101: begin
                sel_mask = MASK_P3P0;
                use_nor  = 1'b1;
            end
            3'b110:  sel_mask = MASK_P3P0;
            3'b111:  sel_mask = MASK_P3P2;
            default: sel_mask = '0;
        endcase
    end

    // outputs drop out: forced to the gate's neutral value
    assign use_mask = sel_mask & ~pin_is_out;
    assign gate_out = use_nor ? ~|(pins_sync & use_mask)
                              : ~&(pins_sync | ~use_mask);

    // wake when gate output equals the programmed level
    always_comb begin
        nxt_evt = 1'b0;
        if (source != 3'b000) begin
            nxt_evt = ~(gate_out ^ wake_level);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            evt_ff <= 1'b0;
        end else begin
            evt_ff <= nxt_evt;
        end
    end

    // a held level gives one request on its leading edge only
    assign second_req = nxt_evt & ~evt_ff;
    // either register's event counts
    assign any_wake   = second_req | primary_wake_req;

    ////////////////////////////////////////////////////////////////////////
    // stop / recovery sequencer
    always_comb begin
        nxt_state       = state_ff;
        nxt_delay       = delay_ff;
        nxt_resume      = 1'b0;
        nxt_woke_second = woke_second_ff;
        case (state_ff)
            PS_RUN: begin
                if (stop_req) begin
                    nxt_state = PS_STOP;
                end
            end
            PS_STOP: begin
                if (any_wake) begin
                    nxt_woke_second = second_req;
                    if (primary_ff[DELAY_SEL_BIT]) begin
                        nxt_state = PS_DELAY;
                        nxt_delay = '0;
                    end else begin
                        // no settling wait: execution restarts next cycle
                        nxt_state  = PS_RUN;
                        nxt_resume = 1'b1;
                    end
                end
            end
            PS_DELAY: begin
                // oscillator settling time before the core restarts
                if (delay_ff >= POR_CYC - 20'd1) begin
                    nxt_state  = PS_RUN;
                    nxt_resume = 1'b1;
                end else begin
                    nxt_delay = delay_ff + 20'd1;
                end
            end
            default: nxt_state = PS_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff       <= PS_RUN;
            delay_ff       <= '0;
            resume_ff      <= 1'b0;
            woke_second_ff <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            delay_ff       <= nxt_delay;
            resume_ff      <= nxt_resume;
            woke_second_ff <= nxt_woke_second;
        end
    end

    assign in_stop      = (state_ff != PS_RUN);
    assign resume_pulse = resume_ff;

    ////////////////////////////////////////////////////////////////////////
    // watchdog: halted with the core only when software asks; off in stop
    assign wdt_run = !in_stop && (!halt_active || wdt_mode_ff[WDT_HALT_BIT]);

    srwc_wdt #(
        .CYC_0 (WDT_CYC_A),
        .CYC_1 (WDT_CYC_B),
        .CYC_2 (WDT_CYC_C),
        .CYC_3 (WDT_CYC_D)
    ) u_wdt (
        .clock      (clock),
        .srst       (srst),
        .run        (wdt_run),
        .refresh    (wdt_refresh),
        .period_sel (wdt_mode_ff[WDT_SEL_MSB:WDT_SEL_LSB]),
        .timeout    (wdt_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wake_in_stop;
        (state_ff == PS_STOP) && any_wake;
    endsequence

    sequence s_wake_fast;
        s_wake_in_stop ##0 !primary_ff[DELAY_SEL_BIT];
    endsequence

    sequence s_wake_slow;
        s_wake_in_stop ##0 primary_ff[DELAY_SEL_BIT];
    endsequence

    a_reset_source_zero: assert property (@(posedge clock)
        srst |=> (source == 3'b000) && !in_stop)
        else $error("source field not cleared by reset");

    a_zero_source_quiet: assert property (@(posedge clock) disable iff (srst)
        (source == 3'b000) |-> !second_req)
        else $error("wake request with source zero");

    a_output_pin_masked: assert property (@(posedge clock) disable iff (srst)
        (use_mask & pin_is_out) == '0)
        else $error("output pin used in wake gate");

    a_level_polarity: assert property (@(posedge clock) disable iff (srst)
        (source != 3'b000) |=> (evt_ff == ~($past(gate_out) ^ $past(wake_level))))
        else $error("wake level polarity wrong");

    a_single_request: assert property (@(posedge clock) disable iff (srst)
        second_req |=> !second_req)
        else $error("more than one request per event");

    a_either_wakes: assert property (@(posedge clock) disable iff (srst)
        s_wake_in_stop |=> (state_ff != PS_STOP))
        else $error("wake event did not leave stop");

    a_resume_at_once: assert property (@(posedge clock) disable iff (srst)
        s_wake_fast |=> resume_pulse && !in_stop)
        else $error("undelayed wake did not resume next cycle");

    a_delay_holds: assert property (@(posedge clock) disable iff (srst)
        s_wake_slow |=> (!resume_pulse && in_stop) [*8])
        else $error("delayed wake resumed too early");

    a_delay_ends: assert property (@(posedge clock) disable iff (srst)
        ((state_ff == PS_DELAY) && (delay_ff >= POR_CYC - 20'd1)) |=> resume_pulse && !in_stop)
        else $error("delay end did not resume");

    // a pin level reaches the gate exactly two edges after it is sampled
    a_pin_sync_two: assert property (@(posedge clock) disable iff (srst)
        (!$past(srst) && !$past(srst, 2)) |-> (pins_sync == $past(pins_raw, 2)))
        else $error("wake pins not passed through two flops");

    a_write_only_read: assert property (@(posedge clock) disable iff (srst)
        (reg_rd && reg_addr == SECOND_WAKE_OFS) |=> (reg_rdata == 8'h00))
        else $error("write-only bits visible on read");

    a_halt_wdt_gate: assert property (@(posedge clock) disable iff (srst)
        (halt_active && !in_stop) |-> (wdt_run == wdt_mode_ff[WDT_HALT_BIT]))
        else $error("watchdog halt gating wrong");

endmodule

`default_nettype wire

/* srwc_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

// far-side pin model: wake pins driven by outside circuitry
module srwc_pin_model (
    input  wire logic        clock,
    input  wire logic        slow,
    input  wire logic [12:0] want,
    output logic      [7:0]  port2_pins,
    output logic      [2:0]  port3_pins,
    output logic             port0_pin0,
    output logic             port0_pin7
);
    logic [12:0] lag_ff [3];

    ////////////////////////////////////////////////////////////////////////////////
    // pins move on the falling edge so they are never aligned to the sampling edge;
    // slow mode lets them settle three cycles late, like a sluggish driver
    always @(negedge clock) begin
        lag_ff[0] <= want;
        lag_ff[1] <= lag_ff[0];
        lag_ff[2] <= lag_ff[1];
        {port0_pin7, port0_pin0, port3_pins, port2_pins} <= slow ? lag_ff[2] : want;
    end
endmodule

`default_nettype wire

/* test_stop_recovery_and_watchdog_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

module test_stop_recovery_and_watchdog_ctrl;
    import srwc_pkg::*;

    // short counts keep the run brief; the delay and watchdog expectations derive from these
    localparam int POR = 20;
    localparam int W0  = 16;
    localparam int W1  = 32;
    localparam int W2  = 64;
    localparam int W3  = 128;

    logic        clock            = 1'b0;
    logic        srst             = 1'b1;
    logic        reg_wr           = 1'b0;
    logic        reg_rd           = 1'b0;
    logic        stop_req         = 1'b0;
    logic        primary_wake_req = 1'b0;
    logic        halt_active      = 1'b0;
    logic        wdt_refresh      = 1'b0;
    logic        port0_out0       = 1'b0;
    logic        port0_out7       = 1'b0;
    logic        slow             = 1'b0;
    logic [7:0]  reg_addr         = 8'h00;
    logic [7:0]  reg_wdata        = 8'h00;
    logic [7:0]  port2_is_output  = 8'h00;
    logic [12:0] want             = 13'h0000;
    logic [7:0]  reg_rdata;
    logic [7:0]  port2_pins;
    logic [2:0]  port3_pins;
    logic        port0_pin0;
    logic        port0_pin7;
    logic        in_stop;
    logic        resume_pulse;
    logic        wdt_timeout;
    int          n_fail           = 0;
    int          n_checks         = 0;
    logic [12:0] msk [8]          = '{13'h0000, MASK_P2LO, MASK_P2ALL, MASK_P3, MASK_P3,
                                      MASK_P3P0, MASK_P3P0, MASK_P3P2};
    int          wcy [4]          = '{W0, W1, W2, W3};
    logic [7:0]  ra [5]           = '{PRIMARY_WAKE_OFS, SECOND_WAKE_OFS, STATUS_OFS,
                                      WDT_MODE_OFS, 8'h40};
    logic [7:0]  re [5]           = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};

    always #50 clock = ~clock;

    srwc_pin_model PINS (
        .clock      (clock),
        .slow       (slow),
        .want       (want),
        .port2_pins (port2_pins),
        .port3_pins (port3_pins),
        .port0_pin0 (port0_pin0),
        .port0_pin7 (port0_pin7)
    );

    srwc_top #(
        .POR_CYC   (20'(POR)),
        .WDT_CYC_A (20'(W0)),
        .WDT_CYC_B (20'(W1)),
        .WDT_CYC_C (20'(W2)),
        .WDT_CYC_D (20'(W3))
    ) DUT (
        .clock            (clock),
        .srst             (srst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .port2_pins       (port2_pins),
        .port2_is_output  (port2_is_output),
        .port3_pins       (port3_pins),
        .port0_pin0       (port0_pin0),
        .port0_pin7       (port0_pin7),
        .port0_out0       (port0_out0),
        .port0_out7       (port0_out7),
        .primary_wake_req (primary_wake_req),
        .stop_req         (stop_req),
        .halt_active      (halt_active),
        .wdt_refresh      (wdt_refresh),
        .in_stop          (in_stop),
        .resume_pulse     (resume_pulse),
        .wdt_timeout      (wdt_timeout)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checking and bus helpers
    task automatic summarize();
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic stop();
        @(posedge clock);
        stop_req <= 1'b1;
        @(posedge clock);
        stop_req <= 1'b0;
        #1 chk("in_stop_entry", in_stop, 1);
    endtask

    task automatic pulse_primary();
        @(posedge clock);
        primary_wake_req <= 1'b1;
        @(posedge clock);
        primary_wake_req <= 1'b0;
        #1;
    endtask

    // bounded wait for the resume pulse; n counts cycles spent waiting
    task automatic wait_res(output int n);
        n = 0;
        while (resume_pulse !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1 n++;
        end
        chk("resume_pulse", resume_pulse, 1);
        chk("in_stop_exit", in_stop, 0);
    endtask

    // idle keeps the gate away from the level, decoy moves only unselected pins
    task automatic run_wake(input logic [2:0] code, input logic lvl, input logic [12:0] mk,
                            input logic [12:0] wk, input int lim);
        int          n;
        logic [12:0] idle;
        idle = lvl ? mk : 13'h0000;
        @(posedge clock);
        want <= idle;
        wr(SECOND_WAKE_OFS, {1'b0, lvl, 1'b0, code, 2'b00});
        repeat (4) @(posedge clock);
        stop();
        @(posedge clock);
        want <= idle | ~mk;
        repeat (8) @(posedge clock);
        #1 chk("decoy_ignored", in_stop, 1);
        @(posedge clock);
        want <= wk;
        wait_res(n);
        chk("wake_latency", n <= lim, 1);
    endtask

    task automatic kick();
        @(posedge clock);
        wdt_refresh <= 1'b1;
        @(posedge clock);
        wdt_refresh <= 1'b0;
        #1;
    endtask

    task automatic wdt_wait(output int n);
        n = 0;
        while (wdt_timeout !== 1'b1 && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard: the sequence needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        summarize();
    end

    initial begin
        logic [7:0] d;
        int         n;
        int         cnt;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        // unmapped write must disturb nothing; then reset values
        wr(8'h40, 8'hff);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], d);
            chk("reset_value", d, re[i]);
        end
        @(posedge clock);
        #1 chk("rdata_idle", reg_rdata, 0);
        // source 000 after reset: pins cannot wake, primary wakes at once
        stop();
        @(posedge clock);
        want <= 13'h1fff;
        repeat (6) @(posedge clock);
        want <= 13'h0000;
        repeat (6) @(posedge clock);
        #1 chk("por_only", in_stop, 1);
        pulse_primary();
        wait_res(n);
        chk("no_delay", n, 0);
        wr(SECOND_WAKE_OFS, 8'h5c);
        rd(SECOND_WAKE_OFS, d);
        chk("write_only", d, 0);
        // every nonzero source code at both recovery levels
        for (int lv = 0; lv < 2; lv++) begin
            for (int c = 1; c < 8; c++) begin
                run_wake(3'(c), 1'(lv), msk[c], lv ? 13'h0000 : msk[c], 5);
            end
        end
        // output pins drop out of the gate; slow pins as well
        @(posedge clock);
        port2_is_output <= 8'h01;
        slow            <= 1'b1;
        run_wake(3'd1, 1'b0, MASK_P2LO, 13'h000e, 9);
        @(posedge clock);
        port0_out0 <= 1'b1;
        port0_out7 <= 1'b1;
        run_wake(3'd6, 1'b0, MASK_P3P0, MASK_P3, 9);
        rd(STATUS_OFS, d);
        chk("status_second", d, 8'h0c);
        // a held wake condition gives no second request; primary still works
        stop();
        repeat (8) @(posedge clock);
        #1 chk("held_once", in_stop, 1);
        pulse_primary();
        wait_res(n);
        chk("either_source", n, 0);
        rd(STATUS_OFS, d);
        chk("status_primary", d, 8'h04);
        // delay selected, as a crystal clock needs
        wr(PRIMARY_WAKE_OFS, 8'h20);
        stop();
        pulse_primary();
        wait_res(n);
        chk("por_delay", n >= POR && n <= POR + 3, 1);
        // watchdog periods, counted while halted with the halt bit set
        @(posedge clock);
        halt_active <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(WDT_MODE_OFS, {5'b0_0000, 1'b1, 2'(s)});
            kick();
            wdt_wait(n);
            chk("wdt_period", n >= wcy[s] - 1 && n <= wcy[s] + 2, 1);
        end
        wr(WDT_MODE_OFS, 8'h00);
        kick();
        cnt = 0;
        repeat (3 * W0) begin
            @(posedge clock);
            #1 cnt += int'(wdt_timeout === 1'b1);
        end
        chk("wdt_halt_stop", cnt, 0);
        @(posedge clock);
        halt_active <= 1'b0;
        wdt_wait(n);
        chk("wdt_run_again", n >= W0 - 1 && n <= W0 + 2, 1);
        summarize();
    end
endmodule

`default_nettype wire
